// File: src/phy_misc_pkg.sv
package phy_misc_pkg;
  localparam int          CLK_FREQ_HZ     = 20_000_000;
  localparam int          RESET_MIN_NS    = 1000;
  localparam int          RESET_MIN_CYC   = (RESET_MIN_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
  localparam int          BLINK_HALF_MS   = 50;
  localparam int          BLINK_HALF_CYC  = BLINK_HALF_MS * (CLK_FREQ_HZ / 1000);
  localparam int          CNT_W           = 24;

  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_PHY_CTRL    = 8'h04;
  localparam logic [7:0]  REG_ADDR        = 8'h08;
  localparam logic [7:0]  REG_IRQ_STATUS  = 8'h0C;
  localparam logic [7:0]  REG_IRQ_MASK    = 8'h10;
  localparam logic [7:0]  REG_STATUS      = 8'h14;

  localparam int          CTRL_MODE3      = 0;
  localparam int          CTRL_FDX_SEL    = 1;
  localparam int          CTRL_IRQ_EN_A   = 2;
  localparam int          CTRL_IRQ_EN_B   = 3;
  localparam int          CTRL_W          = 4;
  localparam logic [3:0]  CTRL_RESET      = 4'h0;

  localparam int          PC_ADDR_LSB     = 0;
  localparam int          PC_LED_MODE     = 4;
  localparam int          PC_CLK_DIS      = 5;
  localparam int          PC_POL_LSB      = 6;

  localparam int          ADDR_B_LSB      = 8;

  localparam int          EV_LINK_A       = 0;
  localparam int          EV_LINK_B       = 1;
  localparam int          EV_COL_A        = 2;
  localparam int          EV_COL_B        = 3;
  localparam int          EV_W            = 4;
  localparam logic [3:0]  EV_RESET        = 4'h0;

  localparam int          ST_LINK_A       = 0;
  localparam int          ST_LINK_B       = 1;
  localparam int          ST_PD_A         = 2;
  localparam int          ST_PD_B         = 3;
  localparam int          ST_RMII         = 4;
  localparam int          ST_RST_OK       = 5;

  typedef enum logic [1:0] {LED_MODE1, LED_MODE2, LED_MODE3} led_mode_t;
endpackage : phy_misc_pkg

// File: src/phy_strap_reset_led_control.sv
// Summary of operation
// - mac clock follows reference, 25 or 50 MHz
// - disable strap keeps mac clock off
// - three led modes, strap plus register
// - led polarity from sampled strap level
// - mode 1 link led plain link
// - modes 2/3 link led blinks on activity
// - speed led shows 100 Mb/s always
// - mode 1 third led shows activity
// - mode 2 collision, mode 3 optional duplex
// - reset held high at least 1 us
// - reset restores defaults, resamples straps
// - shared pin default low powerdown input
// - interrupt mode pin open drain low
// - straps sampled in reset, pins resume after
// - address strap bits 4:1 latched in register
// - port a even, port b odd address
module phy_strap_reset_led_control
  import phy_misc_pkg::*;
#(
  parameter int BLINK_CYC = BLINK_HALF_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  input  wire logic        reference_clock_input_i,
  input  wire logic        rmii_mode_i,
  output logic             mac_reference_clock_out_o,
  input  wire logic        clk_disable_strap_i,
  input  wire logic        led_mode_strap_i,
  input  wire logic        phy_addr_strap_bit1_i,
  input  wire logic        phy_addr_strap_bit2_i,
  input  wire logic        phy_addr_strap_bit3_i,
  input  wire logic        phy_addr_strap_bit4_i,
  input  wire logic        link_good_a_i,
  input  wire logic        speed_100_a_i,
  input  wire logic        tx_active_a_i,
  input  wire logic        rx_active_a_i,
  input  wire logic        collision_a_i,
  input  wire logic        full_duplex_a_i,
  input  wire logic        link_good_b_i,
  input  wire logic        speed_100_b_i,
  input  wire logic        tx_active_b_i,
  input  wire logic        rx_active_b_i,
  input  wire logic        collision_b_i,
  input  wire logic        full_duplex_b_i,
  input  wire logic        link_indicator_port_a_i,
  output logic             link_indicator_port_a_o,
  output logic             link_indicator_port_a_oe_o,
  input  wire logic        speed_indicator_port_a_i,
  output logic             speed_indicator_port_a_o,
  output logic             speed_indicator_port_a_oe_o,
  input  wire logic        activity_collision_indicator_port_a_i,
  output logic             activity_collision_indicator_port_a_o,
  output logic             activity_collision_indicator_port_a_oe_o,
  input  wire logic        link_indicator_port_b_i,
  output logic             link_indicator_port_b_o,
  output logic             link_indicator_port_b_oe_o,
  input  wire logic        speed_indicator_port_b_i,
  output logic             speed_indicator_port_b_o,
  output logic             speed_indicator_port_b_oe_o,
  input  wire logic        activity_collision_indicator_port_b_i,
  output logic             activity_collision_indicator_port_b_o,
  output logic             activity_collision_indicator_port_b_oe_o,
  input  wire logic        powerdown_irq_pin_port_a_i,
  output logic             powerdown_irq_pin_port_a_o,
  output logic             powerdown_irq_pin_port_a_oe_o,
  input  wire logic        powerdown_irq_pin_port_b_i,
  output logic             powerdown_irq_pin_port_b_o,
  output logic             powerdown_irq_pin_port_b_oe_o,
  output logic             powerdown_a_o,
  output logic             powerdown_b_o
);

  logic [CTRL_W-1:0] ctrl_reg;
  logic [3:0]        addr_strap_reg;
  logic              led_mode_strap_reg;
  logic              clk_dis_strap_reg;
  logic [5:0]        pol_reg;
  logic              ready_reg;
  logic [CNT_W-1:0]  rst_cnt_reg;
  logic              rst_ok_reg;
  logic              rst_prev_reg;
  logic [EV_W-1:0]   status_reg;
  logic [EV_W-1:0]   status_next;
  logic [EV_W-1:0]   mask_reg;
  logic [EV_W-1:0]   ev_set;
  logic [EV_W-1:0]   ev_clr;
  logic              link_a_prev_reg;
  logic              link_b_prev_reg;
  logic              col_a_prev_reg;
  logic              col_b_prev_reg;
  logic [CNT_W-1:0]  blink_cnt_reg;
  logic              blink_tick;
  logic              blink_phase_reg;
  logic              ack_reg;
  logic [31:0]       rdata_reg;
  logic [31:0]       rdata_next;
  logic              bus_req;
  logic              bus_wr;
  led_mode_t         mode;
  logic [2:0]        led_a;
  logic [2:0]        led_b;
  logic [4:0]        addr_a;
  logic [4:0]        addr_b;
  logic              port_irq_a;
  logic              port_irq_b;

  // led function: {act/col, speed, link}
  function automatic logic [2:0] led_drive(input led_mode_t m, input logic link, input logic spd,
                                           input logic act, input logic col, input logic fdx,
                                           input logic fdx_sel, input logic phase);
    logic l;
    logic t;
    l = link;
    t = act;
    case (m)
      LED_MODE1: begin
        l = link;
        t = act;
      end
      LED_MODE2: begin
        l = link & ~(act & phase);
        t = col;
      end
      LED_MODE3: begin
        l = link & ~(act & phase);
        t = fdx_sel ? fdx : col;
      end
      default: begin
        l = link;
        t = act;
      end
    endcase
    return {t, spd, l};
  endfunction : led_drive

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_strap_reg     <= {phy_addr_strap_bit4_i, phy_addr_strap_bit3_i,
                             phy_addr_strap_bit2_i, phy_addr_strap_bit1_i};
      led_mode_strap_reg <= led_mode_strap_i;
      clk_dis_strap_reg  <= clk_disable_strap_i;
      pol_reg            <= {activity_collision_indicator_port_b_i, speed_indicator_port_b_i,
                             link_indicator_port_b_i, activity_collision_indicator_port_a_i,
                             speed_indicator_port_a_i, link_indicator_port_a_i};
    end
  end

  always_ff @(posedge clk_i) begin
    rst_prev_reg <= rst_i;
    if (rst_i) begin
      if (rst_cnt_reg != CNT_W'(RESET_MIN_CYC)) begin
        rst_cnt_reg <= rst_cnt_reg + CNT_W'(1);
      end
      if (!rst_prev_reg) begin
        rst_cnt_reg <= CNT_W'(1);
      end
    end
    if (rst_prev_reg && !rst_i) begin
      rst_ok_reg <= (rst_cnt_reg >= CNT_W'(RESET_MIN_CYC));
    end
  end

  // pins return to function after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= 1'b1;
    end
  end

  assign addr_a = {addr_strap_reg, 1'b0};
  assign addr_b = {addr_strap_reg, 1'b1};

  assign mac_reference_clock_out_o = reference_clock_input_i & ready_reg & ~clk_dis_strap_reg;

  always_comb begin
    if (ctrl_reg[CTRL_MODE3]) begin
      mode = LED_MODE3;
    end else if (led_mode_strap_reg) begin
      mode = LED_MODE2;
    end else begin
      mode = LED_MODE1;
    end
  end

  assign blink_tick = (blink_cnt_reg == CNT_W'(BLINK_CYC - 1));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blink_cnt_reg   <= '0;
      blink_phase_reg <= 1'b0;
    end else if (blink_tick) begin
      blink_cnt_reg   <= '0;
      blink_phase_reg <= ~blink_phase_reg;
    end else begin
      blink_cnt_reg   <= blink_cnt_reg + CNT_W'(1);
    end
  end

  assign led_a = led_drive(mode, link_good_a_i, speed_100_a_i, tx_active_a_i | rx_active_a_i,
                           collision_a_i, full_duplex_a_i, ctrl_reg[CTRL_FDX_SEL], blink_phase_reg);
  assign led_b = led_drive(mode, link_good_b_i, speed_100_b_i, tx_active_b_i | rx_active_b_i,
                           collision_b_i, full_duplex_b_i, ctrl_reg[CTRL_FDX_SEL], blink_phase_reg);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_indicator_port_a_o               <= 1'b0;
      speed_indicator_port_a_o              <= 1'b0;
      activity_collision_indicator_port_a_o <= 1'b0;
      link_indicator_port_b_o               <= 1'b0;
      speed_indicator_port_b_o              <= 1'b0;
      activity_collision_indicator_port_b_o <= 1'b0;
    end else begin
      link_indicator_port_a_o               <= led_a[0] ^ pol_reg[0];
      speed_indicator_port_a_o              <= led_a[1] ^ pol_reg[1];
      activity_collision_indicator_port_a_o <= led_a[2] ^ pol_reg[2];
      link_indicator_port_b_o               <= led_b[0] ^ pol_reg[3];
      speed_indicator_port_b_o              <= led_b[1] ^ pol_reg[4];
      activity_collision_indicator_port_b_o <= led_b[2] ^ pol_reg[5];
    end
  end

  assign link_indicator_port_a_oe_o               = ready_reg;
  assign speed_indicator_port_a_oe_o              = ready_reg;
  assign activity_collision_indicator_port_a_oe_o = ready_reg;
  assign link_indicator_port_b_oe_o               = ready_reg;
  assign speed_indicator_port_b_oe_o              = ready_reg;
  assign activity_collision_indicator_port_b_oe_o = ready_reg;

  // event edges
  always_ff @(posedge clk_i) begin
    link_a_prev_reg <= link_good_a_i;
    link_b_prev_reg <= link_good_b_i;
    col_a_prev_reg  <= collision_a_i;
    col_b_prev_reg  <= collision_b_i;
  end

  always_comb begin
    ev_set            = '0;
    ev_set[EV_LINK_A] = ready_reg & (link_good_a_i ^ link_a_prev_reg);
    ev_set[EV_LINK_B] = ready_reg & (link_good_b_i ^ link_b_prev_reg);
    ev_set[EV_COL_A]  = ready_reg & collision_a_i & ~col_a_prev_reg;
    ev_set[EV_COL_B]  = ready_reg & collision_b_i & ~col_b_prev_reg;
  end

  // wishbone slave, write at the acked edge
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_wr  = bus_req & wb_we_i & ack_reg;
  assign ev_clr  = (bus_wr && wb_adr_i == REG_IRQ_STATUS && wb_sel_i[0]) ? wb_dat_i[EV_W-1:0] : '0;
  // sticky status, set beats clear
  assign status_next = (status_reg & ~ev_clr) | ev_set;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg   <= CTRL_RESET;
      mask_reg   <= EV_RESET;
      status_reg <= EV_RESET;
    end else begin
      status_reg <= status_next;
      if (bus_wr && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
        ctrl_reg <= wb_dat_i[CTRL_W-1:0];
      end
      if (bus_wr && wb_adr_i == REG_IRQ_MASK && wb_sel_i[0]) begin
        mask_reg <= wb_dat_i[EV_W-1:0];
      end
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    case (wb_adr_i)
      REG_CTRL: begin
        rdata_next[CTRL_W-1:0] = ctrl_reg;
      end
      REG_PHY_CTRL: begin
        rdata_next[PC_ADDR_LSB +: 4] = addr_strap_reg;
        rdata_next[PC_LED_MODE]      = led_mode_strap_reg;
        rdata_next[PC_CLK_DIS]       = clk_dis_strap_reg;
        rdata_next[PC_POL_LSB +: 6]  = pol_reg;
      end
      REG_ADDR: begin
        rdata_next[4:0]              = addr_a;
        rdata_next[ADDR_B_LSB +: 5]  = addr_b;
      end
      REG_IRQ_STATUS: begin
        rdata_next[EV_W-1:0] = status_reg;
      end
      REG_IRQ_MASK: begin
        rdata_next[EV_W-1:0] = mask_reg;
      end
      REG_STATUS: begin
        rdata_next[ST_LINK_A] = link_good_a_i;
        rdata_next[ST_LINK_B] = link_good_b_i;
        rdata_next[ST_PD_A]   = powerdown_a_o;
        rdata_next[ST_PD_B]   = powerdown_b_o;
        rdata_next[ST_RMII]   = rmii_mode_i;
        rdata_next[ST_RST_OK] = rst_ok_reg;
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg   <= bus_req & ~ack_reg;
      rdata_reg <= rdata_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign irq_o    = |(status_reg & mask_reg);

  assign port_irq_a = |(status_reg & mask_reg & 4'h5);
  assign port_irq_b = |(status_reg & mask_reg & 4'hA);

  assign powerdown_irq_pin_port_a_o    = 1'b0;
  assign powerdown_irq_pin_port_b_o    = 1'b0;
  assign powerdown_irq_pin_port_a_oe_o = ready_reg & ctrl_reg[CTRL_IRQ_EN_A] & port_irq_a;
  assign powerdown_irq_pin_port_b_oe_o = ready_reg & ctrl_reg[CTRL_IRQ_EN_B] & port_irq_b;

  assign powerdown_a_o = ready_reg & ~ctrl_reg[CTRL_IRQ_EN_A] & ~powerdown_irq_pin_port_a_i;
  assign powerdown_b_o = ready_reg & ~ctrl_reg[CTRL_IRQ_EN_B] & ~powerdown_irq_pin_port_b_i;

  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  a_bus_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    s_bus_req |=> s_ack_pulse) else $error("ack not a single pulse");
  a_strap_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> $stable(addr_strap_reg) && $stable(pol_reg)) else $error("strap changed");
  a_addr_pair: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !wb_we_i && wb_adr_i == REG_ADDR |-> wb_dat_o[0] == 1'b0 && wb_dat_o[8] == 1'b1
    && wb_dat_o[4:1] == wb_dat_o[12:9]) else $error("port address pair wrong");
  a_pins_released: assert property (@(posedge clk_i)
    rst_i |=> !link_indicator_port_a_oe_o && !powerdown_irq_pin_port_a_oe_o) else $error("pin driven in reset");
  a_speed_led: assert property (@(posedge clk_i) disable iff (rst_i)
    ready_reg |=> speed_indicator_port_a_o == ($past(speed_100_a_i) ^ pol_reg[1])) else $error("speed led wrong");
  a_link_mode1: assert property (@(posedge clk_i) disable iff (rst_i)
    ready_reg && mode == LED_MODE1 |=> link_indicator_port_b_o == ($past(link_good_b_i) ^ pol_reg[3]))
    else $error("mode1 link led wrong");
  a_act_mode1: assert property (@(posedge clk_i) disable iff (rst_i)
    ready_reg && mode == LED_MODE1 && (tx_active_a_i || rx_active_a_i)
    |=> activity_collision_indicator_port_a_o == ~pol_reg[2]) else $error("activity led wrong");
  a_col_mode2: assert property (@(posedge clk_i) disable iff (rst_i)
    ready_reg && mode == LED_MODE2 |=> activity_collision_indicator_port_a_o == ($past(collision_a_i) ^ pol_reg[2]))
    else $error("collision led wrong");
  a_blink_flip: assert property (@(posedge clk_i) disable iff (rst_i)
    blink_tick |=> blink_phase_reg != $past(blink_phase_reg)) else $error("blink phase stuck");
  a_irq_pin_low: assert property (@(posedge clk_i) disable iff (rst_i)
    ready_reg && ctrl_reg[CTRL_IRQ_EN_A] && port_irq_a |-> powerdown_irq_pin_port_a_oe_o
    && !powerdown_irq_pin_port_a_o && !powerdown_a_o) else $error("irq pin not pulled low");
  a_pd_default: assert property (@(posedge clk_i) disable iff (rst_i)
    ready_reg && !ctrl_reg[CTRL_IRQ_EN_B] && !powerdown_irq_pin_port_b_i |-> powerdown_b_o
    && !powerdown_irq_pin_port_b_oe_o) else $error("powerdown not entered");
  a_clk_disabled: assert property (@(posedge clk_i) disable iff (rst_i)
    clk_dis_strap_reg |-> !mac_reference_clock_out_o) else $error("mac clock not disabled");
  a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    ev_set[EV_LINK_A] |=> status_reg[EV_LINK_A]) else $error("event lost");
  a_ctrl_default: assert property (@(posedge clk_i)
    rst_i |=> ctrl_reg == CTRL_RESET && status_reg == EV_RESET) else $error("defaults not restored");

endmodule : phy_strap_reset_led_control

// File: test/phy_far_side_model.sv
module phy_far_side_model (
  input  wire logic [7:0] pin_drv_i,
  input  wire logic [7:0] pin_oe_i,
  input  wire logic [5:0] led_strap_i,
  input  wire logic [1:0] pd_low_i,
  output logic      [7:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      // resistor level while led pin released
      pin_o[k] = pin_oe_i[k] ? pin_drv_i[k] : led_strap_i[k];
    end
    for (int k = 0; k < 2; k++) begin
      // pull-up, host switch or open drain pulls low
      pin_o[6+k] = ~pd_low_i[k] & ~(pin_oe_i[6+k] & ~pin_drv_i[6+k]);
    end
  end
endmodule : phy_far_side_model

// File: test/phy_strap_reset_led_control_tb_top.sv
module phy_strap_reset_led_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import phy_misc_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0, addr_strap = 4'hA;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic        wb_ack_o, irq_o, mac_reference_clock_out_o, powerdown_a_o, powerdown_b_o;
  logic        reference_clock_input_i = 1'b0, rmii_mode_i = 1'b0, clk_disable_strap_i = 1'b0;
  logic        led_mode_strap_i = 1'b0, link_good_a_i = 1'b0, speed_100_a_i = 1'b0, tx_active_a_i = 1'b0;
  logic        rx_active_a_i = 1'b0, collision_a_i = 1'b0, full_duplex_a_i = 1'b0, link_good_b_i = 1'b0;
  logic        speed_100_b_i = 1'b0, tx_active_b_i = 1'b0, rx_active_b_i = 1'b0, collision_b_i = 1'b0;
  logic        full_duplex_b_i = 1'b0;
  logic [5:0]  led_strap = 6'b000101;
  logic [1:0]  pd_low = 2'b00;
  logic [7:0]  pin, drv, oe;
  logic link_indicator_port_a_o, link_indicator_port_a_oe_o, speed_indicator_port_a_o, speed_indicator_port_a_oe_o;
  logic link_indicator_port_b_o, link_indicator_port_b_oe_o, speed_indicator_port_b_o, speed_indicator_port_b_oe_o;
  logic activity_collision_indicator_port_a_o, activity_collision_indicator_port_a_oe_o;
  logic activity_collision_indicator_port_b_o, activity_collision_indicator_port_b_oe_o;
  logic powerdown_irq_pin_port_a_o, powerdown_irq_pin_port_a_oe_o;
  logic powerdown_irq_pin_port_b_o, powerdown_irq_pin_port_b_oe_o;
  wire phy_addr_strap_bit1_i = addr_strap[0];
  wire phy_addr_strap_bit2_i = addr_strap[1];
  wire phy_addr_strap_bit3_i = addr_strap[2];
  wire phy_addr_strap_bit4_i = addr_strap[3];
  wire link_indicator_port_a_i = pin[0];
  wire speed_indicator_port_a_i = pin[1];
  wire activity_collision_indicator_port_a_i = pin[2];
  wire link_indicator_port_b_i = pin[3];
  wire speed_indicator_port_b_i = pin[4];
  wire activity_collision_indicator_port_b_i = pin[5];
  wire powerdown_irq_pin_port_a_i = pin[6];
  wire powerdown_irq_pin_port_b_i = pin[7];
  int err_count = 0;
  int checked = 0;
  logic [31:0] ones;
  assign drv = {powerdown_irq_pin_port_b_o, powerdown_irq_pin_port_a_o, activity_collision_indicator_port_b_o,
                speed_indicator_port_b_o, link_indicator_port_b_o, activity_collision_indicator_port_a_o,
                speed_indicator_port_a_o, link_indicator_port_a_o};
  assign oe = {powerdown_irq_pin_port_b_oe_o, powerdown_irq_pin_port_a_oe_o, activity_collision_indicator_port_b_oe_o,
               speed_indicator_port_b_oe_o, link_indicator_port_b_oe_o, activity_collision_indicator_port_a_oe_o,
               speed_indicator_port_a_oe_o, link_indicator_port_a_oe_o};
  phy_strap_reset_led_control #(.BLINK_CYC(8)) uut (.*);
  phy_far_side_model far_side (.pin_drv_i(drv), .pin_oe_i(oe), .led_strap_i(led_strap), .pd_low_i(pd_low),
                               .pin_o(pin));
  always #25 clk_i = ~clk_i;
  task automatic report_and_stop;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      $display("MISMATCH at %0t: no bus answer", $time);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  task automatic count_link;
    ones = 0;
    repeat (40) begin
      @(posedge clk_i);
      ones += 32'(link_indicator_port_a_o);
    end
  endtask : count_link
  task automatic do_reset(input int n);
    rst_i <= 1'b1;
    cyc(n);
    rst_i <= 1'b0;
  endtask : do_reset
  initial begin
    cyc(3000);
    err_count++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    report_and_stop();
  end
  initial begin
    do_reset(10);
    // power-up width unknown, short reset again
    cyc(1);
    do_reset(10);
    rd(REG_PHY_CTRL, 32'h0000014A);
    rd(REG_ADDR, 32'h00001514);
    addr_strap <= 4'h3;
    clk_disable_strap_i <= 1'b1;
    rmii_mode_i <= 1'b1;
    rd(REG_PHY_CTRL, 32'h0000014A);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q & 32'h30, 32'h10);
    chk(32'(oe[5:0]), 32'h3F);
    reference_clock_input_i <= 1'b1;
    cyc(1);
    chk(32'(mac_reference_clock_out_o), 32'h1);
    reference_clock_input_i <= 1'b0;
    link_good_a_i <= 1'b1;
    speed_100_a_i <= 1'b1;
    tx_active_a_i <= 1'b1;
    cyc(2);
    chk(32'(mac_reference_clock_out_o), 32'h0);
    chk(32'(drv[2:0]), 32'h2);
    count_link();
    chk(ones, 0);
    tx_active_a_i <= 1'b0;
    speed_100_a_i <= 1'b0;
    cyc(2);
    chk(32'(drv[2:0]), 32'h4);
    wb(1'b1, REG_CTRL, 32'h1);
    rx_active_a_i <= 1'b1;
    collision_a_i <= 1'b1;
    count_link();
    chk(32'(ones > 0 && ones < 40), 32'h1);
    chk(32'(drv[2]), 32'h0);
    collision_a_i <= 1'b0;
    full_duplex_a_i <= 1'b1;
    wb(1'b1, REG_CTRL, 32'h3);
    cyc(2);
    chk(32'(drv[2]), 32'h0);
    full_duplex_a_i <= 1'b0;
    rx_active_a_i <= 1'b0;
    cyc(2);
    chk(32'(drv[2]), 32'h1);
    wb(1'b1, REG_IRQ_STATUS, 32'hF);
    wb(1'b1, REG_IRQ_MASK, 32'h1);
    link_good_a_i <= 1'b0;
    cyc(3);
    chk({irq_o, powerdown_irq_pin_port_a_oe_o}, 32'h2);
    wb(1'b1, REG_CTRL, 32'h4);
    cyc(1);
    chk(32'(pin[6]), 32'h0);
    wb(1'b1, REG_IRQ_STATUS, 32'h1);
    link_good_b_i <= 1'b1;
    cyc(3);
    chk({irq_o, powerdown_irq_pin_port_a_oe_o}, 32'h0);
    rd(REG_IRQ_STATUS, 32'h2);
    wb(1'b1, REG_IRQ_MASK, 32'h2);
    wb(1'b1, REG_CTRL, 32'h8);
    cyc(1);
    chk({pin[7], irq_o}, 32'h1);
    wb(1'b1, REG_CTRL, 32'h0);
    pd_low <= 2'b01;
    cyc(3);
    chk({powerdown_a_o, powerdown_b_o}, 32'h2);
    pd_low <= 2'b00;
    cyc(3);
    chk(32'(powerdown_a_o), 32'h0);
    rd(8'h3C, 32'h0);
    addr_strap <= 4'h5;
    led_mode_strap_i <= 1'b1;
    led_strap <= 6'b110010;
    reference_clock_input_i <= 1'b1;
    do_reset(25);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q & 32'h20, 32'h20);
    rd(REG_PHY_CTRL, 32'h00000CB5);
    rd(REG_ADDR, 32'h00000B0A);
    rd(REG_CTRL, 32'h0);
    chk(32'(mac_reference_clock_out_o), 32'h0);
    collision_a_i <= 1'b1;
    cyc(2);
    chk(32'(drv[2:1]), 32'h3);
    chk(32'(drv[5:3]), 32'h7);
    report_and_stop();
  end
endmodule : phy_strap_reset_led_control_tb_top
